//--- test_port_map.vh
// Constants for the programming test-port block: offsets, fields, commands, timings
`ifndef TEST_PORT_MAP_VH
`define TEST_PORT_MAP_VH

// Register byte offsets
`define REG_STATUS        8'h00
`define REG_CONTROL       8'h04
`define REG_FLASH_ADDR    8'h08
`define REG_FLASH_DATA    8'h0C
`define REG_DEVICE_ID     8'h10
`define REG_LINK_STATE    8'h14

// Status word bit positions
`define ST_FLASH_BUSY_BIT    2
`define ST_CONFIG_READY_BIT  3
`define ST_CODE_PROTECT_BIT  7

// Control and link-state fields
`define CTL_PROTECT_BIT      0
`define LNK_DEBUG_PORT_BIT   0
`define LNK_DEBUG_BOOT_BIT   1
`define LNK_RESET_CMD_BIT    2
`define LNK_FLASH_EN_BIT     3

// Reset values
`define CONTROL_RESET     1'b0
`define FLASH_ADDR_RESET  4'h0

// Instruction register commands (5 bits)
`define IR_WIDTH              5
`define IR_CAPTURE_VALUE      5'h01
`define IR_SELECT_CHIP_PORT   5'h04
`define IR_SELECT_DEBUG_PORT  5'h05
`define IR_CHIP_PORT_CMD_REG  5'h07
`define IR_DEBUG_BOOT_CMD     5'h0C

// Chip port command register data commands (8 bits)
`define DR_WIDTH              8
`define CMD_STATUS_QUERY      8'h00
`define CMD_RELEASE_RESET     8'hD0
`define CMD_ASSERT_RESET      8'hD1
`define CMD_CHIP_ERASE        8'hFC
`define CMD_FLASH_ENABLE      8'hFE

// Timing
`define CLK_FREQ_MHZ          25
`define ERASE_TIME_US         400
`define CFG_LOAD_TIME_US      2

`endif

//--- pin_sync.v
// Two-stage synchroniser for link pins with clock edge detection
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 4
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] pins,
    output wire [WIDTH-1:0] pins_sync,
    output wire             rise0,
    output wire             fall0
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;
    reg             last_q;

    // First stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
            last_q <= 1'b0;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            last_q <= sync_q[0];
        end
    end

    // Edge of bit 0 (the link clock) from settled samples
    assign pins_sync = sync_q;
    assign rise0     = sync_q[0] & ~last_q;
    assign fall0     = ~sync_q[0] & last_q;
endmodule

//--- test_port_ctrl.v
// Programming test port: chip-port command logic, status word, self-timed chip erase
`timescale 1ns/1ps
`include "test_port_map.vh"
module test_port_ctrl #(
    parameter         FLASH_DEPTH  = 16,
    parameter         FLASH_AW     = 4,
    parameter         ERASE_CYCLES = `ERASE_TIME_US * `CLK_FREQ_MHZ,
    parameter [31:0]  DEVICE_ID    = 32'h0000_1234 // Arbitrary identity value
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    input  wire        link_clk,
    input  wire        mode_sel,
    input  wire        link_data_in,
    output reg         link_data_out,
    output reg         link_data_oe,
    input  wire        master_clear_n,
    output wire        cpu_reset_hold,
    output wire        cpu_debug_boot,
    output wire        flash_enable
);
    localparam [3:0] TEST_RESET = 4'h0, RUN_IDLE  = 4'h1, SEL_DR   = 4'h2, CAP_DR   = 4'h3,
                     SHIFT_DR   = 4'h4, EXIT1_DR  = 4'h5, PAUSE_DR = 4'h6, EXIT2_DR = 4'h7,
                     UPD_DR     = 4'h8, SEL_IR    = 4'h9, CAP_IR   = 4'hA, SHIFT_IR = 4'hB,
                     EXIT1_IR   = 4'hC, PAUSE_IR  = 4'hD, EXIT2_IR = 4'hE, UPD_IR   = 4'hF;
    // Count kept in eight bits; cut on purpose from the integer product
    localparam integer CFG_CYCLES_I = `CFG_LOAD_TIME_US * `CLK_FREQ_MHZ;
    localparam [7:0]   CFG_CYCLES   = CFG_CYCLES_I[7:0];

    wire [3:0] pins_s;
    wire       lck_rise;
    wire       lck_fall;
    reg  [3:0] tap_q;
    reg  [3:0] tap_d;
    reg  [`IR_WIDTH-1:0] ir_sr_q;
    reg  [`IR_WIDTH-1:0] ir_q;
    reg  [`DR_WIDTH-1:0] dr_sr_q;
    reg        debug_port_q;
    reg        debug_boot_q;
    reg        reset_cmd_q;
    reg        flash_en_q;
    reg        protect_q;
    reg        erase_busy_q;
    reg [31:0] erase_cnt_q;
    reg [7:0]  cfg_cnt_q;
    reg [FLASH_AW-1:0] faddr_q;
    reg [31:0] flash_mem [0:FLASH_DEPTH-1];
    reg        pready_q;
    integer    i;

    // Link pins: clock on bit 0; master clear sampled too
    pin_sync #(.WIDTH(4)) u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pins      ({master_clear_n, link_data_in, mode_sel, link_clk}),
        .pins_sync (pins_s),
        .rise0     (lck_rise),
        .fall0     (lck_fall)
    );

    wire tms_s    = pins_s[1];
    wire tdi_s    = pins_s[2];
    wire master_clear_n_n_s = pins_s[3];
    wire cfg_ready = (cfg_cnt_q == CFG_CYCLES);
    wire chip_cmd_sel = ~debug_port_q && (ir_q == `IR_CHIP_PORT_CMD_REG);

    // Status word assembled from live state
    function [7:0] status_word;
        input ready;
        input busy;
        input prot;
        begin
            status_word = 8'h00;
            status_word[`ST_CONFIG_READY_BIT] = ready;
            status_word[`ST_FLASH_BUSY_BIT]   = busy;
            status_word[`ST_CODE_PROTECT_BIT] = ~prot;
        end
    endfunction

    // Standard test controller transitions on mode-select
    always @* begin
        case (tap_q)
            TEST_RESET: tap_d = tms_s ? TEST_RESET : RUN_IDLE;
            RUN_IDLE:   tap_d = tms_s ? SEL_DR : RUN_IDLE;
            SEL_DR:     tap_d = tms_s ? SEL_IR : CAP_DR;
            CAP_DR:     tap_d = tms_s ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:   tap_d = tms_s ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:   tap_d = tms_s ? UPD_DR : PAUSE_DR;
            PAUSE_DR:   tap_d = tms_s ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:   tap_d = tms_s ? UPD_DR : SHIFT_DR;
            UPD_DR:     tap_d = tms_s ? SEL_DR : RUN_IDLE;
            SEL_IR:     tap_d = tms_s ? TEST_RESET : CAP_IR;
            CAP_IR:     tap_d = tms_s ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:   tap_d = tms_s ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:   tap_d = tms_s ? UPD_IR : PAUSE_IR;
            PAUSE_IR:   tap_d = tms_s ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:   tap_d = tms_s ? UPD_IR : SHIFT_IR;
            UPD_IR:     tap_d = tms_s ? SEL_DR : RUN_IDLE;
            default:    tap_d = TEST_RESET;
        endcase
    end

    // Controller, shift registers and command decode on link clock rise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_q        <= TEST_RESET;
            ir_sr_q      <= {`IR_WIDTH{1'b0}};
            ir_q         <= `IR_SELECT_CHIP_PORT;
            dr_sr_q      <= {`DR_WIDTH{1'b0}};
            debug_port_q <= 1'b0;
            debug_boot_q <= 1'b0;
            reset_cmd_q  <= 1'b0;
            flash_en_q   <= 1'b0;
        end else if (lck_rise) begin
            tap_q <= tap_d;
            case (tap_q)
                TEST_RESET: begin
                    ir_q         <= `IR_SELECT_CHIP_PORT;
                    debug_port_q <= 1'b0;
                end
                CAP_IR:   ir_sr_q <= `IR_CAPTURE_VALUE;
                SHIFT_IR: ir_sr_q <= {tdi_s, ir_sr_q[`IR_WIDTH-1:1]};
                UPD_IR: begin
                    ir_q <= ir_sr_q;
                    if (ir_sr_q == `IR_SELECT_CHIP_PORT)
                        debug_port_q <= 1'b0;
                    else if (ir_sr_q == `IR_SELECT_DEBUG_PORT)
                        debug_port_q <= 1'b1;
                    else if (debug_port_q && ir_sr_q == `IR_DEBUG_BOOT_CMD)
                        debug_boot_q <= 1'b1;
                end
                // Status captured fresh for every transfer
                CAP_DR: dr_sr_q <= status_word(cfg_ready, erase_busy_q, protect_q);
                SHIFT_DR: dr_sr_q <= {tdi_s, dr_sr_q[`DR_WIDTH-1:1]};
                UPD_DR: begin
                    if (chip_cmd_sel) begin
                        case (dr_sr_q)
                            `CMD_ASSERT_RESET:  reset_cmd_q <= 1'b1;
                            `CMD_RELEASE_RESET: reset_cmd_q <= 1'b0;
                            `CMD_FLASH_ENABLE:  flash_en_q  <= 1'b1;
                            default:            flash_en_q  <= flash_en_q;
                        endcase
                    end
                end
                default: ir_q <= ir_q;
            endcase
        end
    end

    // Out data changes on link clock fall, driven only while shifting
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_data_out <= 1'b0;
            link_data_oe  <= 1'b0;
        end else if (lck_fall) begin
            link_data_oe  <= (tap_q == SHIFT_DR) || (tap_q == SHIFT_IR);
            link_data_out <= (tap_q == SHIFT_IR) ? ir_sr_q[0] : dr_sr_q[0];
        end
    end

    wire erase_go = lck_rise && (tap_q == UPD_DR) && chip_cmd_sel &&
                    (dr_sr_q == `CMD_CHIP_ERASE) && !erase_busy_q;

    // Configuration load after reset, then self-timed erase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_cnt_q    <= 8'h00;
            erase_busy_q <= 1'b0;
            erase_cnt_q  <= 32'h0000_0000;
        end else begin
            if (!cfg_ready)
                cfg_cnt_q <= cfg_cnt_q + 8'h01;
            if (erase_go) begin
                erase_busy_q <= 1'b1;
                erase_cnt_q  <= 32'h0000_0000;
            end else if (erase_busy_q) begin
                if (erase_cnt_q == ERASE_CYCLES - 1)
                    erase_busy_q <= 1'b0;
                erase_cnt_q <= erase_cnt_q + 32'h0000_0001;
            end
        end
    end

    wire erase_done = erase_busy_q && (erase_cnt_q == ERASE_CYCLES - 1);
    wire apb_acc    = psel && penable && pready_q;
    wire apb_wr     = apb_acc && pwrite;

    // Flash contents: one at a time written, all set to ones on erase finish
    always @(posedge pclk) begin
        if (erase_done) begin
            for (i = 0; i < FLASH_DEPTH; i = i + 1)
                flash_mem[i] <= 32'hFFFF_FFFF;
        end else if (apb_wr && paddr == `REG_FLASH_DATA && !erase_busy_q) begin
            flash_mem[faddr_q] <= flash_mem[faddr_q] & pwdata; // Programming only clears bits
        end
    end

    // Protection lives in configuration memory, so erase removes it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protect_q <= `CONTROL_RESET;
            faddr_q   <= `FLASH_ADDR_RESET;
        end else begin
            if (erase_done)
                protect_q <= 1'b0;
            else if (apb_wr && paddr == `REG_CONTROL)
                protect_q <= pwdata[`CTL_PROTECT_BIT];
            if (apb_wr && paddr == `REG_FLASH_ADDR)
                faddr_q <= pwdata[FLASH_AW-1:0];
        end
    end

    // APB slave: one wait state, answer registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
        end else begin
            pready_q <= psel && penable && !pready_q;
            if (psel && penable && !pready_q) begin
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
                case (paddr)
                    `REG_STATUS:     prdata <= {24'h00_0000, status_word(cfg_ready, erase_busy_q, protect_q)};
                    `REG_CONTROL:    prdata <= {31'h0000_0000, protect_q};
                    `REG_FLASH_ADDR: prdata <= {{(32-FLASH_AW){1'b0}}, faddr_q};
                    `REG_FLASH_DATA: prdata <= flash_mem[faddr_q];
                    `REG_DEVICE_ID: prdata <= DEVICE_ID;
                    `REG_LINK_STATE: prdata <= {28'h000_0000, flash_en_q, reset_cmd_q, debug_boot_q, debug_port_q};
                    default:         pslverr <= 1'b1;
                endcase
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    assign pready         = pready_q;
    // Core held by pin or by command; boot mode takes effect at release
    assign cpu_reset_hold = ~master_clear_n_n_s | reset_cmd_q;
    assign cpu_debug_boot = debug_boot_q;
    assign flash_enable   = flash_en_q;
endmodule

//--- test_port_ctrl_asserts.sv
// Concurrent checks on the test-port block's bus answer and core control pins
`timescale 1ns/1ps
`include "test_port_map.vh"
module test_port_ctrl_asserts #(
    parameter [31:0] DEVICE_ID = 32'h0000_0000
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        master_clear_n,
    input wire logic        cpu_reset_hold,
    input wire logic        cpu_debug_boot
);
    // Word-aligned offsets up to the link-state word are the only mapped places
    wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `REG_LINK_STATE);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answer: exactly one wait state, only in the access phase, one cycle long
    property p_one_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
    a_one_wait: assert property (p_one_wait) else $error("answer not after one wait state");
    property p_ready_in_access; pready |-> psel && penable; endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("answer outside access phase");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("answer held too long");

    // Error answer only for unmapped offsets, and then with zero data
    property p_err_map; pready |-> (pslverr == !mapped); endproperty
    a_err_map: assert property (p_err_map) else $error("error flag does not match address map");
    property p_err_zero; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read returned data");

    // Identity word never changes, erase or write notwithstanding
    property p_id_const; pready && !pwrite && paddr == `REG_DEVICE_ID |-> prdata == DEVICE_ID; endproperty
    a_id_const: assert property (p_id_const) else $error("identity word changed");

    // Pin held low keeps the core in reset once through the synchroniser
    property p_clear_hold; !master_clear_n [*4] |-> cpu_reset_hold; endproperty
    a_clear_hold: assert property (p_clear_hold) else $error("core not held while clear pin low");

    // Debug boot request stays until the block reset
    property p_boot_sticky; cpu_debug_boot |=> cpu_debug_boot; endproperty
    a_boot_sticky: assert property (p_boot_sticky) else $error("debug boot request dropped");
endmodule

bind test_port_ctrl test_port_ctrl_asserts #(.DEVICE_ID(DEVICE_ID)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clear_n(master_clear_n), .cpu_reset_hold(cpu_reset_hold), .cpu_debug_boot(cpu_debug_boot)
);

//--- prog_link_model.sv
// Programmer-side link model: drives link clock, mode-select and data in
`timescale 1ns/1ps
`include "test_port_map.vh"
module prog_link_model (
    input  wire logic pclk,
    output logic      link_clk,
    output logic      mode_sel,
    output logic      link_data_in,
    input  wire logic link_data_out
);
    localparam logic [5:0] MODE_PAT = 6'b01_1111;

    // Link clock stands low between frames
    initial begin
        link_clk     = 1'b0;
        mode_sel     = 1'b0;
        link_data_in = 1'b0;
    end

    // One link period of eight bus clocks; data out is taken at the rise
    task tick(input logic t, input logic d, output logic o);
        mode_sel     <= t;
        link_data_in <= d;
        repeat (4) @(posedge pclk);
        o = link_data_out;
        link_clk     <= 1'b1;
        repeat (4) @(posedge pclk);
        link_clk     <= 1'b0;
    endtask

    // Five ones reach test reset, the closing zero lands in run-test/idle
    task set_mode;
        logic o;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) tick(MODE_PAT[i], 1'b0, o);
    endtask

    // Header to shift state, LSB first with mode-select on the last bit, footer to idle
    task shift(input logic ir, input logic [7:0] d, input int n, output logic [7:0] q);
        logic o;
        q = 8'h00;
        @(posedge pclk);
        tick(1'b1, 1'b0, o);
        if (ir) tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        tick(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, d[i], o);
            q[i] = o;
        end
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        link_data_in <= ~d[n-1]; // Released line shows no stale bit
    endtask

    task send_ir(input logic [4:0] c);
        logic [7:0] q;
        shift(1'b1, {3'b000, c}, `IR_WIDTH, q);
    endtask

    task xfer_dr(input logic [7:0] d, output logic [7:0] q);
        shift(1'b0, d, `DR_WIDTH, q);
    endtask
endmodule

//--- program_mode_status_erase_entry_tb_top.sv
// Testbench for the programming test-port block with a programmer link model
`timescale 1ns/1ps
`include "test_port_map.vh"
module program_mode_status_erase_entry_tb_top;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [31:0] m; logic e;} row_t;
    localparam logic [31:0] DEV_ID = 32'h0000_A5C3; // Arbitrary identity value
    logic        pclk           = 1'b0;
    logic        presetn        = 1'b0;
    logic        psel           = 1'b0;
    logic        penable        = 1'b0;
    logic        pwrite         = 1'b0;
    logic [7:0]  paddr          = 8'h00;
    logic [31:0] pwdata         = 32'h0000_0000;
    logic        master_clear_n = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, link_clk, mode_sel, link_data_in, link_data_out, link_data_oe;
    wire         cpu_reset_hold, cpu_debug_boot, flash_enable;
    int          n_mismatch     = 0;
    int          checked        = 0;
    int          cyc            = 0;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  st;
    logic        oe_seen        = 1'b0;
    row_t        rows [9];

    always #20 pclk = ~pclk;

    // Remembers that the data-out driver was ever turned on
    always @(posedge pclk) begin
        if (link_data_oe)
            oe_seen <= 1'b1;
    end

    test_port_ctrl #(.ERASE_CYCLES(40), .DEVICE_ID(DEV_ID)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
        .mode_sel(mode_sel), .link_data_in(link_data_in), .link_data_out(link_data_out),
        .link_data_oe(link_data_oe), .master_clear_n(master_clear_n), .cpu_reset_hold(cpu_reset_hold),
        .cpu_debug_boot(cpu_debug_boot), .flash_enable(flash_enable));

    prog_link_model prog (.pclk(pclk), .link_clk(link_clk), .mode_sel(mode_sel),
        .link_data_in(link_data_in), .link_data_out(link_data_out));

    task close_out;
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bus master: setup, access, hold until the answer, then release
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Hang guard: a few thousand cycles of link traffic expected
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out;
        end
    end

    initial begin
        rows = '{'{1'b1, `REG_CONTROL, 32'h1, 32'h0, 32'h0, 1'b0},
                 '{1'b0, `REG_CONTROL, 32'h0, 32'h1, 32'h1, 1'b0},
                 '{1'b0, `REG_STATUS, 32'h0, 32'h08, 32'h8C, 1'b0},
                 '{1'b1, `REG_DEVICE_ID, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b0},
                 '{1'b0, `REG_DEVICE_ID, 32'h0, DEV_ID, 32'hFFFF_FFFF, 1'b0},
                 '{1'b1, `REG_FLASH_ADDR, 32'h5, 32'h0, 32'h0, 1'b0},
                 '{1'b0, `REG_FLASH_ADDR, 32'h0, 32'h5, 32'hF, 1'b0},
                 '{1'b1, 8'h1C, 32'h0, 32'h0, 32'h0, 1'b1},
                 '{1'b0, 8'h20, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (60) @(posedge pclk);
        chk("reset_hold", 32'h1, {31'h0, cpu_reset_hold});
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("rdata", rows[i].x, rd & rows[i].m);
            chk("slverr", {31'h0, rows[i].e}, {31'h0, er});
        end
        // Status over the link, then a self-timed erase polled to completion
        prog.set_mode();
        prog.send_ir(`IR_SELECT_CHIP_PORT);
        prog.send_ir(`IR_CHIP_PORT_CMD_REG);
        prog.xfer_dr(`CMD_STATUS_QUERY, st);
        chk("link_status", 32'h08, {24'h0, st & 8'h8C});
        chk("oe_shift", 32'h1, {31'h0, oe_seen});
        chk("oe_idle", 32'h0, {31'h0, link_data_oe});
        prog.xfer_dr(`CMD_CHIP_ERASE, st);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk("busy", 32'h4, rd & 32'h4);
        st = 8'h00;
        for (int i = 0; i < 20 && st[3:2] !== 2'b10; i++) prog.xfer_dr(`CMD_STATUS_QUERY, st);
        chk("erase_done", 32'h08, {24'h0, st & 8'h0C});
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, `REG_FLASH_ADDR, 32'(i));
            apb(1'b0, `REG_FLASH_DATA, 32'h0);
            chk("flash", 32'hFFFF_FFFF, rd);
        end
        apb(1'b1, `REG_FLASH_DATA, 32'h0F0F_0F0F);
        apb(1'b0, `REG_FLASH_DATA, 32'h0);
        chk("flash_and", 32'h0F0F_0F0F, rd);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk("unprotect", 32'h80, rd & 32'h80);
        apb(1'b0, `REG_DEVICE_ID, 32'h0);
        chk("dev_id", DEV_ID, rd);
        // Four-wire entry: debug boot with the pin low, then release the pin
        prog.send_ir(`IR_SELECT_DEBUG_PORT);
        prog.send_ir(`IR_DEBUG_BOOT_CMD);
        chk("boot4", 32'h1, {31'h0, cpu_debug_boot});
        @(posedge pclk);
        master_clear_n <= 1'b1;
        repeat (4) @(negedge pclk);
        chk("hold4", 32'h0, {31'h0, cpu_reset_hold});
        // Second reset in mid-run, then two-wire entry by commands
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(negedge pclk);
        chk("boot_rst", 32'h0, {30'h0, cpu_debug_boot, flash_enable});
        prog.set_mode();
        prog.send_ir(`IR_SELECT_CHIP_PORT);
        prog.send_ir(`IR_DEBUG_BOOT_CMD);
        chk("boot_refused", 32'h0, {31'h0, cpu_debug_boot});
        prog.send_ir(`IR_CHIP_PORT_CMD_REG);
        // Status check first; reset cleared protection, so bit 7 reads one
        prog.xfer_dr(`CMD_STATUS_QUERY, st);
        chk("link_status2", 32'h88, {24'h0, st & 8'h8C});
        prog.xfer_dr(`CMD_ASSERT_RESET, st);
        chk("hold_cmd", 32'h1, {31'h0, cpu_reset_hold});
        prog.send_ir(`IR_SELECT_DEBUG_PORT);
        prog.send_ir(`IR_DEBUG_BOOT_CMD);
        chk("boot2", 32'h1, {31'h0, cpu_debug_boot});
        prog.send_ir(`IR_SELECT_CHIP_PORT);
        prog.send_ir(`IR_CHIP_PORT_CMD_REG);
        prog.xfer_dr(`CMD_RELEASE_RESET, st);
        chk("hold_rel", 32'h0, {31'h0, cpu_reset_hold});
        prog.xfer_dr(`CMD_FLASH_ENABLE, st);
        chk("flash_en", 32'h1, {31'h0, flash_enable});
        // Debug port selected again, then the link-state word read back over the bus
        prog.send_ir(`IR_SELECT_DEBUG_PORT);
        apb(1'b0, `REG_LINK_STATE, 32'h0);
        chk("link_state", 32'hB, rd & 32'hF);
        close_out;
    end
endmodule
